/* rtl/acrb_core.sv */
/*
 * Configuration register bank of a four-input sampling converter: two
 * write-only 10-bit registers loaded from the parallel data port, decoded
 * into the settings that steer the converter.
 * Assumes host strobes and data are synchronous to clock and that
 * chip select already merges the device select lines.
 */
//
// What this block does
// - Two ten-bit configuration registers exist
// - Write stores data lines into addressed register
// - Address 00 main, 01 aux, others reserved
// - Address in bits 11:10; registers write-only
// - Bit 0 picks external reference; bit 1 reserved
// - Bit 2 requests power down
// - Writes and reads still work while sleeping
// - Bits 3-4 pick input or input count
// - Bits 5-6 count pairs, reset 01
// - Bit 7 enables autoscan
// - Bits 8-9 inject one of three test voltages
// - Plain mode picks one single-ended input
// - Pair mode picks pair A or B
// - Autoscan cycles two to four single inputs
// - Autoscan mixes single inputs with pair B
// - Autoscan alternates pair A and pair B
// - Aux holds reset, restart, style, format, offset
// - Soft reset restores defaults until cleared
// - Restart bit restarts the frame marker generator
// - Style bit turns write strobe into read/write select
// - Format bit picks twos complement or binary
`timescale 1ns/1ps

module acrb_core
    import acrb_pkg::*;
(
    // Clock and reset
    input  wire logic                    clock,
    input  wire logic                    rst_n,
    // Host parallel port
    input  wire logic                    cs_n,
    input  wire logic                    wr_n,
    input  wire logic                    rd_n,
    input  wire logic [WORD_W-1:0]       data_in,
    // Port status
    output logic                         read_active,
    output logic                         soft_reset_active,
    output logic                         frame_marker_restart,
    // Main register settings
    output logic                         ref_external,
    output logic                         sleep_request,
    output logic [1:0]                   probe_sel,
    output logic [CNT_W-1:0]             scan_count,
    output logic [SLOTS*SRC_W-1:0]       scan_slots,
    // Auxiliary register settings
    output logic                         strobe_style,
    output logic                         number_format_sel,
    output logic                         offset_cal
);

    logic [REG_W-1:0]       main_config_q, main_config_d;
    logic [REG_W-1:0]       aux_config_q, aux_config_d;
    logic                   wr_level_q, wr_level_d;
    logic                   read_q, read_d;
    logic                   restart_q, restart_d;
    logic [CNT_W-1:0]       count_q, count_d;
    logic [SLOTS*SRC_W-1:0] slots_q, slots_d;
    logic                   wr_level;
    logic                   wr_take;
    logic [1:0]             addr;
    logic [REG_W-1:0]       wdata;

    // Write level: low write strobe in both styles
    assign wr_level = !cs_n && !wr_n;
    assign wr_take  = wr_level && !wr_level_q;
    assign addr     = data_in[ADDR_HI:ADDR_LO];
    assign wdata    = data_in[REG_W-1:0];

    // Input selection decode over scan, pair count and pick fields
    function automatic void decode_sel(
        input  logic [REG_W-1:0]       cfg,
        output logic [CNT_W-1:0]       cnt,
        output logic [SLOTS*SRC_W-1:0] sl
    );
        logic [4:0] key;
        key = {cfg[M_SCAN], cfg[M_PAIR_HI], cfg[M_PAIR_LO], cfg[M_PICK_LO+1], cfg[M_PICK_LO]};
        cnt = CNT_NONE;
        sl  = '0;
        case (key)
            5'h00, 5'h01, 5'h02, 5'h03: begin
                cnt = CNT_ONE;
                sl  = {9'h000, 1'b0, key[1:0]};
            end
            5'h04: begin
                cnt = CNT_ONE;
                sl  = {9'h000, SRC_PAIR_A};
            end
            5'h05: begin
                cnt = CNT_ONE;
                sl  = {9'h000, SRC_PAIR_B};
            end
            5'h11: begin
                cnt = CNT_TWO;
                sl  = {6'h00, SRC_A_NEG, SRC_A_POS};
            end
            5'h12: begin
                cnt = CNT_THREE;
                sl  = {3'h0, SRC_B_POS, SRC_A_NEG, SRC_A_POS};
            end
            5'h13: begin
                cnt = CNT_FOUR;
                sl  = {SRC_B_NEG, SRC_B_POS, SRC_A_NEG, SRC_A_POS};
            end
            5'h15: begin
                cnt = CNT_TWO;
                sl  = {6'h00, SRC_PAIR_B, SRC_A_POS};
            end
            5'h16: begin
                cnt = CNT_THREE;
                sl  = {3'h0, SRC_PAIR_B, SRC_A_NEG, SRC_A_POS};
            end
            5'h19: begin
                cnt = CNT_TWO;
                sl  = {6'h00, SRC_PAIR_B, SRC_PAIR_A};
            end
            default: begin
                cnt = CNT_NONE;
                sl  = '0;
            end
        endcase
    endfunction

    // Register bank next state
    always_comb begin
        main_config_d = main_config_q;
        aux_config_d  = aux_config_q;
        restart_d     = 1'b0;
        wr_level_d    = wr_level;
        // Writes are honoured regardless of power down
        if (wr_take && addr == ADDR_AUX) begin
            aux_config_d = wdata;
            restart_d    = wdata[A_RESTART];
            if (wdata[A_SOFT_RST]) begin
                main_config_d = MAIN_RESET;
                aux_config_d  = AUX_RESET | (10'h001 << A_SOFT_RST);
            end
        end else if (wr_take && addr == ADDR_MAIN && !aux_config_q[A_SOFT_RST]) begin
            main_config_d = wdata;
        end
        // Reserved addresses fall through unstored
        if (strobe_style == 1'b1) begin
            read_d = !cs_n && wr_n;
        end else begin
            read_d = !cs_n && !rd_n;
        end
        decode_sel(main_config_d, count_d, slots_d);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            main_config_q <= MAIN_RESET;
            aux_config_q  <= AUX_RESET;
            wr_level_q    <= 1'b0;
            read_q        <= 1'b0;
            restart_q     <= 1'b0;
            count_q       <= CNT_ONE;
            slots_q       <= {9'h000, SRC_PAIR_A};
        end else begin
            main_config_q <= main_config_d;
            aux_config_q  <= aux_config_d;
            wr_level_q    <= wr_level_d;
            read_q        <= read_d;
            restart_q     <= restart_d;
            count_q       <= count_d;
            slots_q       <= slots_d;
        end
    end

    // Settings straight from register bits, scan count and slots from a registered decode; nothing reads back
    assign ref_external         = main_config_q[M_REF];
    assign sleep_request        = main_config_q[M_SLEEP];
    assign probe_sel            = main_config_q[M_PROBE_LO+1:M_PROBE_LO];
    assign scan_count           = count_q;
    assign scan_slots           = slots_q;
    assign strobe_style         = aux_config_q[A_STYLE];
    assign number_format_sel    = aux_config_q[A_FORMAT];
    assign offset_cal           = aux_config_q[A_OFFSET];
    assign soft_reset_active    = aux_config_q[A_SOFT_RST];
    assign frame_marker_restart = restart_q;
    assign read_active          = read_q;

    // Checks
    sequence s_main_write;
        wr_take && addr == ADDR_MAIN && !soft_reset_active;
    endsequence

    sequence s_aux_write;
        wr_take && addr == ADDR_AUX;
    endsequence

    sequence s_soft_reset;
        s_aux_write ##0 data_in[A_SOFT_RST];
    endsequence

    main_store_a: assert property (@(posedge clock) disable iff (!rst_n)
        s_main_write |=> main_config_q == $past(data_in[REG_W-1:0]))
        else $error("main register did not store write data");

    aux_store_a: assert property (@(posedge clock) disable iff (!rst_n)
        s_aux_write ##0 !data_in[A_SOFT_RST] |=> aux_config_q == $past(data_in[REG_W-1:0]))
        else $error("aux register did not store write data");

    reserved_addr_a: assert property (@(posedge clock) disable iff (!rst_n)
        wr_take && addr[1] |=> $stable(main_config_q) && $stable(aux_config_q))
        else $error("reserved address changed a register");

    soft_defaults_a: assert property (@(posedge clock) disable iff (!rst_n)
        s_soft_reset |=> main_config_q == MAIN_RESET && soft_reset_active
            ##1 soft_reset_active && main_config_q == MAIN_RESET)
        else $error("soft reset did not restore and hold defaults");

    soft_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
        soft_reset_active && !(wr_take && addr == ADDR_AUX) |=> soft_reset_active)
        else $error("soft reset released without a clearing write");

    restart_pulse_a: assert property (@(posedge clock) disable iff (!rst_n)
        s_aux_write ##0 data_in[A_RESTART] |=> frame_marker_restart ##1 !frame_marker_restart)
        else $error("frame marker restart not a single pulse");

    sleep_access_a: assert property (@(posedge clock) disable iff (!rst_n)
        sleep_request && !strobe_style && !cs_n && !rd_n |=> read_active)
        else $error("read refused while sleeping");

    style_read_a: assert property (@(posedge clock) disable iff (!rst_n)
        strobe_style && !cs_n && wr_n && rd_n ##1 strobe_style |-> read_active)
        else $error("combined select did not signal read");

    single_pick_a: assert property (@(posedge clock) disable iff (!rst_n)
        main_config_q[M_SCAN:M_PAIR_LO] == 3'h0 |->
            scan_count == CNT_ONE && scan_slots[1:0] == main_config_q[M_PICK_LO+1:M_PICK_LO])
        else $error("single-ended pick decoded wrongly");

    two_pairs_a: assert property (@(posedge clock) disable iff (!rst_n)
        main_config_q[M_SCAN:M_PICK_LO] == 5'h19 |->
            scan_count == CNT_TWO && scan_slots[5:0] == {SRC_PAIR_B, SRC_PAIR_A})
        else $error("two-pair autoscan decoded wrongly");

    four_scan_a: assert property (@(posedge clock) disable iff (!rst_n)
        main_config_q[M_SCAN:M_PICK_LO] == 5'h13 |-> scan_count == CNT_FOUR
            && scan_slots == {SRC_B_NEG, SRC_B_POS, SRC_A_NEG, SRC_A_POS})
        else $error("four-input autoscan decoded wrongly");

    format_track_a: assert property (@(posedge clock) disable iff (!rst_n)
        s_aux_write ##0 !data_in[A_SOFT_RST] |=> number_format_sel == $past(data_in[A_FORMAT]))
        else $error("number format did not follow write");

endmodule

/* pkg/acrb_pkg.sv */
/*
 * Shared constants for the converter configuration register bank:
 * write word layout, field positions, reset values and input source codes.
 * Assumes a 12-bit host write word with the register address on top.
 */
package acrb_pkg;

    localparam int unsigned REG_W   = 10;
    localparam int unsigned WORD_W  = 12;
    localparam int unsigned SLOTS   = 4;
    localparam int unsigned SRC_W   = 3;
    localparam int unsigned CNT_W   = 3;

    // Register address field of the write word
    localparam int unsigned ADDR_LO = 10;
    localparam int unsigned ADDR_HI = 11;
    localparam logic [1:0]  ADDR_MAIN = 2'h0;
    localparam logic [1:0]  ADDR_AUX  = 2'h1;

    // Main register fields
    localparam int unsigned M_REF      = 0;
    localparam int unsigned M_SLEEP    = 2;
    localparam int unsigned M_PICK_LO  = 3;
    localparam int unsigned M_PAIR_LO  = 5;
    localparam int unsigned M_PAIR_HI  = 6;
    localparam int unsigned M_SCAN     = 7;
    localparam int unsigned M_PROBE_LO = 8;

    // Auxiliary register fields
    localparam int unsigned A_SOFT_RST = 0;
    localparam int unsigned A_RESTART  = 1;
    localparam int unsigned A_STYLE    = 6;
    localparam int unsigned A_FORMAT   = 7;
    localparam int unsigned A_OFFSET   = 8;

    localparam logic [9:0] MAIN_RESET = 10'h020;
    localparam logic [9:0] AUX_RESET  = 10'h030;

    typedef enum logic [2:0] {
        SRC_A_POS,
        SRC_A_NEG,
        SRC_B_POS,
        SRC_B_NEG,
        SRC_PAIR_A,
        SRC_PAIR_B
    } acrb_src_e;

    localparam logic [2:0] CNT_NONE = 3'h0;
    localparam logic [2:0] CNT_ONE  = 3'h1;
    localparam logic [2:0] CNT_TWO  = 3'h2;
    localparam logic [2:0] CNT_THREE = 3'h3;
    localparam logic [2:0] CNT_FOUR = 3'h4;

endpackage

/* bench/acrb_host.sv */
/*
 * Host model driving the converter's parallel configuration port.
 * Assumes the bench calls its tasks from one process, one at a time.
 */
`timescale 1ns/1ps

module acrb_host
    import acrb_pkg::*;
(
    // Clock
    input  wire logic              clock,
    // Parallel port
    output logic                   cs_n,
    output logic                   wr_n,
    output logic                   rd_n,
    output logic [WORD_W-1:0]      data_in
);
    initial begin
        cs_n    = 1'b1;
        wr_n    = 1'b1;
        rd_n    = 1'b1;
        data_in = 12'hA5A;
    end

    // One whole word per write; a released bus shows the inverse value
    task automatic write_word(input logic [WORD_W-1:0] w);
        @(posedge clock);
        cs_n    <= 1'b0;
        wr_n    <= 1'b0;
        data_in <= w;
        @(posedge clock);
        cs_n    <= 1'b1;
        wr_n    <= 1'b1;
        data_in <= ~w;
    endtask

    // Read cycle; the write strobe stays high, which reads in combined style
    task automatic start_read(input logic rd_low);
        @(posedge clock);
        cs_n <= 1'b0;
        rd_n <= ~rd_low;
    endtask

    task automatic end_read();
        @(posedge clock);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
    endtask
endmodule

/* bench/tb.sv */
/*
 * Self-checking bench for the configuration register bank.
 * Assumes the host model issues every write; expectations are queued per write.
 */
`timescale 1ns/1ps

module tb
    import acrb_pkg::*;
;
    logic                     clock = 1'b0;
    logic                     rst_n = 1'b0;
    wire                      cs_n, wr_n, rd_n;
    wire  [WORD_W-1:0]        data_in;
    logic                     read_active, soft_reset_active, frame_marker_restart;
    logic                     ref_external, sleep_request, strobe_style;
    logic                     number_format_sel, offset_cal;
    logic [1:0]               probe_sel;
    logic [CNT_W-1:0]         scan_count;
    logic [SLOTS*SRC_W-1:0]   scan_slots;
    logic [9:0]               main_e, aux_e;
    logic [23:0]              exp_q[$];
    logic                     wl_q = 1'b0, tk_q = 1'b0;
    int                       failures = 0;
    int                       n_checks = 0;
    wire  [23:0]              got = {ref_external, sleep_request, probe_sel, scan_count,
        scan_slots, strobe_style, number_format_sel, offset_cal, soft_reset_active,
        frame_marker_restart};

    always #10 clock = ~clock;

    acrb_host i_acrb_host (.clock(clock), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
        .data_in(data_in));

    acrb_core i_acrb_core (.clock(clock), .rst_n(rst_n), .cs_n(cs_n), .wr_n(wr_n),
        .rd_n(rd_n), .data_in(data_in), .read_active(read_active),
        .soft_reset_active(soft_reset_active), .frame_marker_restart(frame_marker_restart),
        .ref_external(ref_external), .sleep_request(sleep_request), .probe_sel(probe_sel),
        .scan_count(scan_count), .scan_slots(scan_slots), .strobe_style(strobe_style),
        .number_format_sel(number_format_sel), .offset_cal(offset_cal));

    function automatic logic [23:0] exp_of(input logic rs);
        logic [14:0] cs;
        cs = 15'h0000;
        case (main_e[7:3])
            5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05:
                cs = {3'h1, 9'h000, main_e[5:3]};
            5'h11: cs = {3'h2, 12'h008};
            5'h12: cs = {3'h3, 12'h088};
            5'h13: cs = {3'h4, 12'h688};
            5'h15: cs = {3'h2, 12'h028};
            5'h16: cs = {3'h3, 12'h148};
            5'h19: cs = {3'h2, 12'h02C};
            default: ;
        endcase
        return {main_e[0], main_e[2], main_e[9:8], cs, aux_e[6], aux_e[7], aux_e[8],
            aux_e[0], rs};
    endfunction

    task automatic cmp(input logic [23:0] e);
        n_checks++;
        if (got !== e) begin
            failures++;
            $display("CHECK FAILED at %0t: outputs %h expected %h", $time, got, e);
        end
    endtask

    // Predict the outcome, queue it, then let the host write
    task automatic wr(input logic [11:0] w);
        logic rs;
        rs = 1'b0;
        if (w[11:10] == ADDR_MAIN && !aux_e[0]) begin
            main_e = w[9:0];
        end else if (w[11:10] == ADDR_AUX && w[0]) begin
            main_e = MAIN_RESET;
            aux_e  = AUX_RESET | 10'h001;
        end else if (w[11:10] == ADDR_AUX) begin
            aux_e = w[9:0];
            rs    = w[1];
        end
        exp_q.push_back(exp_of(rs));
        i_acrb_host.write_word(w);
    endtask

    task automatic rd_chk(input logic rd_low, input logic e);
        i_acrb_host.start_read(rd_low);
        @(posedge clock);
        @(negedge clock);
        n_checks++;
        if (read_active !== e) begin
            failures++;
            $display("CHECK FAILED at %0t: read_active %b expected %b", $time, read_active, e);
        end
        i_acrb_host.end_read();
    endtask

    task automatic complete_run();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Outputs and the restart pulse stand in the cycle after the taking edge
    always @(posedge clock) begin
        wl_q  <= ~cs_n & ~wr_n;
        tk_q  <= ~cs_n & ~wr_n & ~wl_q;
    end

    always @(negedge clock) begin
        if (tk_q && exp_q.size() > 0)
            cmp(exp_q.pop_front());
    end

    initial begin
        void'($urandom(62));
        repeat (2) @(posedge clock);
        main_e = MAIN_RESET;
        aux_e  = AUX_RESET;
        cmp(exp_of(1'b0));
        rst_n <= 1'b1;
        $display("test reset values done");
        for (int k = 0; k < 32; k++)
            wr({ADDR_MAIN, 2'($urandom), 5'(k), 3'($urandom)});
        $display("test input selection done");
        wr({ADDR_AUX, 10'h042});
        rd_chk(1'b0, 1'b1);
        wr({ADDR_AUX, 10'h080});
        wr({ADDR_MAIN, 10'h004});
        rd_chk(1'b1, 1'b1);
        rd_chk(1'b0, 1'b0);
        $display("test strobe styles done");
        wr({ADDR_AUX, 10'h101});
        wr({ADDR_MAIN, 10'h3FF});
        wr({2'h2, 10'h155});
        wr({2'h3, 10'h2AA});
        wr({ADDR_AUX, 10'h100});
        wr({ADDR_MAIN, 10'h3FF});
        $display("test soft reset done");
        repeat (2) @(posedge clock);
        rst_n <= 1'b0;
        @(negedge clock);
        main_e = MAIN_RESET;
        aux_e  = AUX_RESET;
        cmp(exp_of(1'b0));
        @(posedge clock);
        rst_n <= 1'b1;
        wr({ADDR_AUX, 10'h002});
        for (int i = 0; i < 10 && exp_q.size() > 0; i++)
            @(posedge clock);
        if (exp_q.size() > 0) begin
            failures++;
            $display("CHECK FAILED at %0t: writes left unchecked", $time);
        end
        $display("test mid-run reset done");
        complete_run();
    end

    initial begin
        repeat (5000) @(posedge clock);
        failures++;
        $display("CHECK FAILED at %0t: run timed out", $time);
        complete_run();
    end
endmodule
